// ==== hdl/smart_card_mode_control.sv ====
// Smart card mode control: transmit-end timing, status and mode registers
// What this block does
// - Transmit off, no error: done flag held set
// - Set done flag after delay if clean, empty
// - Delay 2.5, 1.5 or 1.0 etu by mode
// - Done flag cleared by read one, write zero
// - DMA write of holding register clears done flag
// - Received multidrop flag unused in card mode
// - Mode register reserved bits read one, ignore writes
// - In card mode, bit three selects LSB or MSB first
// - Seven-bit characters always shift LSB first
// - In card mode, invert bit inverts transmit and receive data
// - Data invert never touches the parity bit
// - Bit zero selects smart card mode
// - Low error signal sample sets error flag
// - Holding empty set on load or transmit off
`timescale 1ns/1ps
`default_nettype none
module smart_card_mode_control
  import card_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic dma_wr_valid,
  input wire logic [7:0] dma_wr_data,
  output logic tx_empty_irq,
  input wire logic shifter_ready,
  output logic tx_load,
  output logic [7:0] tx_shift_data,
  input wire logic tx_char_done,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_mp_bit,
  input wire logic err_sample,
  input wire logic card_err_pin,
  output logic card_mode,
  output logic parity_odd,
  output logic seven_bit,
  output logic irq
);
  initial begin
    if (ADDR_W < 8) $error("ADDR_W must be at least 8");
  end

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic hold_empty;
    logic err_flag;
    logic done_flag;
    logic [2:0] seen;
    logic mp_rx;
    logic mp_tx;
    logic [7:0] mode;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] half_etu;
    logic [7:0] tx_hold;
    logic [7:0] rx_hold;
    logic load;
    logic [7:0] shift_data;
    logic delay_on;
    logic [2:0] halves;
    logic [15:0] div;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic err_s1;
    logic err_s2;
  } state_t;
  state_t s, next_s;
  // Shared by both directions so order and inversion always match
  function automatic logic [7:0] format_char(input logic [7:0] d, input logic msb_first,
                                             input logic invert, input logic seven);
    logic [7:0] v;
    v = invert ? ~d : d;
    if (msb_first && !seven) begin
      v = {<<{v}};
    end
    return v;
  endfunction
  function automatic logic [7:0] status_byte(input state_t t);
    logic [7:0] v;
    v = 8'h00;
    v[ST_HOLD_EMPTY] = t.hold_empty;
    v[ST_ERR_SIG] = t.err_flag;
    v[ST_DONE] = t.done_flag;
    v[ST_MP_RX] = t.mp_rx;
    v[ST_MP_TX] = t.mp_tx;
    return v;
  endfunction
  always_comb begin
    logic do_write;
    logic do_read;
    logic [ADDR_W-1:0] ra;
    logic [7:0] wb;
    logic half_tick;
    logic [7:0] sb;
    logic tx_write;
    logic [7:0] tx_byte;
    do_write = 1'b0;
    do_read = 1'b0;
    ra = araddr;
    wb = s.w_data[7:0];
    half_tick = 1'b0;
    sb = status_byte(s);
    tx_write = 1'b0;
    tx_byte = dma_wr_data;
    next_s = s;
    next_s.load = 1'b0;
    next_s.err_s1 = card_err_pin;
    next_s.err_s2 = s.err_s1;
    // Write address and data are taken in either order
    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      do_write = s.w_strb[0];
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (s.aw_addr[7:0])
        STATUS_OFS, MODE_OFS, CTRL_OFS, HALF_ETU_OFS, TXDATA_OFS, RXDATA_OFS,
        IRQ_STAT_OFS, IRQ_MASK_OFS: ;
        default: next_s.bresp = RESP_SLVERR;
      endcase
      if (s.aw_addr[ADDR_W-1:8] != '0) begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    // Software clears and register writes; hardware sets below win
    if (do_write && s.aw_addr[ADDR_W-1:8] == '0) begin
      case (s.aw_addr[7:0])
        STATUS_OFS: begin
          if (!wb[ST_HOLD_EMPTY] && s.seen[2]) next_s.hold_empty = 1'b0;
          if (!wb[ST_ERR_SIG] && s.seen[1]) next_s.err_flag = 1'b0;
          if (!wb[ST_DONE] && s.seen[0]) next_s.done_flag = 1'b0;
          next_s.seen = 3'b000;
          next_s.mp_tx = wb[ST_MP_TX];
        end
        MODE_OFS: begin
          next_s.mode = wb & ~MODE_RSVD_ONES;
        end
        CTRL_OFS: next_s.ctrl = wb[CTRL_W-1:0];
        HALF_ETU_OFS: begin
          next_s.half_etu[7:0] = wb;
          if (s.w_strb[1]) next_s.half_etu[15:8] = s.w_data[15:8];
        end
        TXDATA_OFS: begin
          tx_write = 1'b1;
          tx_byte = wb;
        end
        IRQ_STAT_OFS: next_s.irq_stat = s.irq_stat & ~wb[IRQ_W-1:0];
        IRQ_MASK_OFS: next_s.irq_mask = wb[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (s.aw_held && s.w_held && !s.bvalid && !s.w_strb[0] && s.w_strb[1]
        && s.aw_addr == ADDR_W'(HALF_ETU_OFS)) begin
      next_s.half_etu[15:8] = s.w_data[15:8];
    end
    // A transfer controller write behaves like a software data write
    if (dma_wr_valid) begin
      tx_write = 1'b1;
      tx_byte = dma_wr_data;
    end
    if (tx_write) begin
      next_s.tx_hold = tx_byte;
      next_s.hold_empty = 1'b0;
      next_s.done_flag = 1'b0;
    end
    // Read channel, one outstanding
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      do_read = 1'b1;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (ra[ADDR_W-1:8] != '0) begin
        next_s.rresp = RESP_SLVERR;
      end else begin
        case (ra[7:0])
          STATUS_OFS: next_s.rdata[7:0] = sb;
          MODE_OFS: next_s.rdata[7:0] = s.mode | MODE_RSVD_ONES;
          CTRL_OFS: next_s.rdata[CTRL_W-1:0] = s.ctrl;
          HALF_ETU_OFS: next_s.rdata[15:0] = s.half_etu;
          TXDATA_OFS: next_s.rdata[7:0] = s.tx_hold;
          RXDATA_OFS: next_s.rdata[7:0] = s.rx_hold;
          IRQ_STAT_OFS: next_s.rdata[IRQ_W-1:0] = s.irq_stat;
          IRQ_MASK_OFS: next_s.rdata[IRQ_W-1:0] = s.irq_mask;
          default: next_s.rresp = RESP_SLVERR;
        endcase
      end
    end
    // Remember flags seen as one, arming the write-zero clear
    if (do_read && ra == ADDR_W'(STATUS_OFS)) begin
      next_s.seen = next_s.seen | {sb[ST_HOLD_EMPTY], sb[ST_ERR_SIG], sb[ST_DONE]};
    end
    // Holding register to shifter
    if (s.ctrl[CT_TX_EN] && !s.hold_empty && shifter_ready && !s.load) begin
      next_s.load = 1'b1;
      next_s.shift_data = s.mode[MD_CARD]
                          ? format_char(s.tx_hold, s.mode[MD_ORDER], s.mode[MD_INVERT],
                                        s.ctrl[CT_SEVEN])
                          : s.tx_hold;
      next_s.hold_empty = 1'b1;
      next_s.irq_stat[IRQ_TX_EMPTY] = 1'b1;
    end
    // Transmit-end delay counted in half etu ticks
    if (s.delay_on) begin
      if (s.div == 16'h0000) begin
        half_tick = 1'b1;
        next_s.div = (s.half_etu == 16'h0000) ? 16'h0000 : s.half_etu - 16'h0001;
      end else begin
        next_s.div = s.div - 16'h0001;
      end
      if (half_tick) begin
        next_s.halves = s.halves - 3'd1;
        if (s.halves == 3'd1) begin
          next_s.delay_on = 1'b0;
          if (!s.err_flag && next_s.hold_empty) begin
            next_s.done_flag = 1'b1;
            next_s.irq_stat[IRQ_TX_DONE] = 1'b1;
          end
        end
      end
    end
    if (tx_char_done) begin
      next_s.delay_on = 1'b1;
      next_s.div = (s.half_etu == 16'h0000) ? 16'h0000 : s.half_etu - 16'h0001;
      if (s.ctrl[CT_GUARD]) begin
        next_s.halves = DONE_HALVES_GUARD;
      end else if (s.ctrl[CT_BLOCK]) begin
        next_s.halves = DONE_HALVES_BLOCK;
      end else begin
        next_s.halves = DONE_HALVES_PLAIN;
      end
    end
    // Error signal returned by the card, low means error
    if (err_sample && !s.err_s2) begin
      next_s.err_flag = 1'b1;
      next_s.irq_stat[IRQ_ERR] = 1'b1;
    end

    // Received character, parity bit never reaches this path
    if (rx_char_valid) begin
      next_s.rx_hold = s.mode[MD_CARD]
                       ? format_char(rx_char_data, s.mode[MD_ORDER], s.mode[MD_INVERT],
                                     s.ctrl[CT_SEVEN])
                       : rx_char_data;
      if (!s.mode[MD_CARD]) begin
        next_s.mp_rx = rx_mp_bit;
      end
      next_s.irq_stat[IRQ_RX] = 1'b1;
    end

    // Transmit disabled forces the idle flags
    if (!s.ctrl[CT_TX_EN]) begin
      next_s.hold_empty = 1'b1;
      next_s.delay_on = 1'b0;
      if (!next_s.err_flag) begin
        next_s.done_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.hold_empty <= 1'b1;
      s.done_flag <= 1'b1;
      s.mode <= MODE_RESET;
      s.half_etu <= HALF_ETU_RESET;
      s.err_s1 <= 1'b1;
      s.err_s2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // One write and one read at a time keeps the slave simple
  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign tx_empty_irq = s.hold_empty && s.ctrl[CT_TX_EN];
  assign tx_load = s.load;
  assign tx_shift_data = s.shift_data;
  assign card_mode = s.mode[MD_CARD];
  assign parity_odd = s.ctrl[CT_PAR_ODD];
  assign seven_bit = s.ctrl[CT_SEVEN];
  assign irq = |(s.irq_stat & s.irq_mask);
endmodule
`default_nettype wire

// ==== hdl/card_pkg.sv ====
// Register map, field positions and reset values of the smart card mode slice
package card_pkg;
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] HALF_ETU_OFS = 8'h0c;
  localparam logic [7:0] TXDATA_OFS = 8'h10;
  localparam logic [7:0] RXDATA_OFS = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;
  // card_status_reg bits
  localparam int ST_HOLD_EMPTY = 7;
  localparam int ST_ERR_SIG = 4;
  localparam int ST_DONE = 2;
  localparam int ST_MP_RX = 1;
  localparam int ST_MP_TX = 0;
  // card_mode_reg bits
  localparam int MD_ORDER = 3;
  localparam int MD_INVERT = 2;
  localparam int MD_CARD = 0;
  localparam logic [7:0] MODE_RSVD_ONES = 8'hf2;
  // control register bits
  localparam int CT_TX_EN = 0;
  localparam int CT_GUARD = 1;
  localparam int CT_BLOCK = 2;
  localparam int CT_SEVEN = 3;
  localparam int CT_PAR_ODD = 4;
  localparam int CTRL_W = 5;
  // Interrupt event bits
  localparam int IRQ_TX_EMPTY = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_RX = 2;
  localparam int IRQ_ERR = 3;
  localparam int IRQ_W = 4;
  // Transmit-end delays in half elementary time units
  localparam logic [2:0] DONE_HALVES_PLAIN = 3'd5;
  localparam logic [2:0] DONE_HALVES_BLOCK = 3'd3;
  localparam logic [2:0] DONE_HALVES_GUARD = 3'd2;
  localparam logic [15:0] HALF_ETU_RESET = 16'h0010;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== tb/card_model.sv ====
// Behavioural card and shifter at the far side of the slice
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_load,
  input wire logic err_en,
  output logic shifter_ready,
  output logic tx_char_done,
  output logic err_sample,
  output logic card_err_pin
);
  // Fixed character time, far shorter than a real frame
  logic [5:0] cnt;
  always @(posedge aclk) begin
    if (!aresetn) cnt <= 6'h00;
    else if (tx_load) cnt <= 6'h28;
    else if (cnt != 6'h00) cnt <= cnt - 6'h01;
  end
  assign shifter_ready = (cnt == 6'h00);
  assign tx_char_done = (cnt == 6'h01);
  assign err_sample = (cnt == 6'h01);
  // Pulled up; low only while a refused character is on the line
  assign card_err_pin = !(err_en && cnt != 6'h00);
endmodule
`default_nettype wire

// ==== tb/card_monitor.sv ====
// Port checker for the smart card mode slice
`timescale 1ns/1ps
`default_nettype none
module card_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic tx_load,
  input wire logic [7:0] tx_shift_data,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wtake; awvalid && awready && wvalid && wready; endsequence
  sequence s_rtake; arvalid && arready; endsequence
  property p_wresp; s_wtake |-> ##[1:2] bvalid; endproperty
  property p_rresp; s_rtake |=> rvalid; endproperty
  property p_bhold; bvalid && !bready |=> bvalid; endproperty
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_arblk; rvalid |-> !arready; endproperty
  property p_wblk; bvalid |-> !awready && !wready; endproperty
  property p_load; tx_load |=> !tx_load; endproperty
  property p_ldata; tx_load |=> $stable(tx_shift_data); endproperty
  // Reset itself must not be masked here
  property p_rst; disable iff (1'b0) !aresetn |=> !irq && !tx_load && !bvalid; endproperty
  a_wresp: assert property (p_wresp)
    else $error("write response missing");
  a_rresp: assert property (p_rresp)
    else $error("read response missing");
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  a_rhold: assert property (p_rhold)
    else $error("read data changed");
  a_arblk: assert property (p_arblk)
    else $error("read taken while busy");
  a_wblk: assert property (p_wblk)
    else $error("write taken while busy");
  a_load: assert property (p_load)
    else $error("load longer than one cycle");
  a_ldata: assert property (p_ldata)
    else $error("shift data moved after load");
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
endmodule
bind smart_card_mode_control card_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .tx_load(tx_load),
  .tx_shift_data(tx_shift_data), .irq(irq));
`default_nettype wire

// ==== tb/test_smart_card_mode_control.sv ====
// Self-checking bench for the smart card mode slice
`timescale 1ns/1ps
`default_nettype none
module test_smart_card_mode_control;
  import card_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic dma_wr_valid = 0, rx_char_valid = 0, rx_mp_bit = 0, err_en = 0;
  logic [7:0] awaddr = 0, araddr = 0, dma_wr_data = 0, rx_char_data = 0, tx_shift_data, d, md, ct;
  logic [31:0] wdata = 0, rdata, rd_v;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp_v;
  logic awready, wready, bvalid, arready, rvalid, tx_empty_irq, shifter_ready, tx_load;
  logic tx_char_done, err_sample, card_err_pin, card_mode, parity_odd, seven_bit, irq;
  logic [2:0] h;
  int n_errors = 0, checks = 0, seed = 3, n;
  always #12.5 aclk = ~aclk;
  smart_card_mode_control dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .dma_wr_valid, .dma_wr_data, .tx_empty_irq, .shifter_ready, .tx_load,
    .tx_shift_data, .tx_char_done, .rx_char_valid, .rx_char_data, .rx_mp_bit, .err_sample,
    .card_err_pin, .card_mode, .parity_odd, .seven_bit, .irq);
  card_model card (.aclk, .aresetn, .tx_load, .err_en, .shifter_ready, .tx_char_done,
    .err_sample, .card_err_pin);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(negedge aclk);
    while (awready !== 1'b1 || wready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    @(negedge aclk);
    while (bvalid !== 1'b1) @(negedge aclk);
    resp_v = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    rd_v = rdata;
    resp_v = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic dma(input logic [7:0] v);
    dma_wr_data <= v;
    dma_wr_valid <= 1'b1;
    @(posedge aclk);
    dma_wr_valid <= 1'b0;
  endtask
  task automatic wait_done();
    @(negedge aclk);
    while (tx_char_done !== 1'b1) @(negedge aclk);
  endtask
  function automatic logic [7:0] fmt(input logic [7:0] v, input logic inv, ord, sev);
    logic [7:0] r;
    r = inv ? ~v : v;
    if (ord && !sev) r = {<<{r}};
    return r;
  endfunction
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(STATUS_OFS);
    chk("status", 32'h84, rd_v);
    rd(MODE_OFS);
    chk("mode", 32'hf2, rd_v);
    rd(8'h20);
    chk("rresp", RESP_SLVERR, resp_v);
    chk("rdata", 32'h0, rd_v);
    wr(8'h24, 32'h0);
    chk("bresp", RESP_SLVERR, resp_v);
    // Slow enough half unit that the three delays cannot overlap
    wr(HALF_ETU_OFS, 32'h4);
    wr(IRQ_MASK_OFS, 32'h2);
    for (int i = 0; i < 8; i++) begin
      md = $random(seed);
      md[0] = 1'b1;
      ct = $random(seed);
      ct[2:0] = {i[0], i[1], 1'b1};
      h = ct[1] ? 3'd2 : (ct[2] ? 3'd3 : 3'd5);
      d = $random(seed);
      wr(MODE_OFS, md);
      rd(MODE_OFS);
      chk("mode", {24'h0, md & 8'h0d | 8'hf2}, rd_v);
      wr(CTRL_OFS, ct[4:0]);
      chk("card_mode", 32'd1, card_mode);
      chk("parity_odd", ct[4], parity_odd);
      chk("seven_bit", ct[3], seven_bit);
      dma(d);
      wr(IRQ_STAT_OFS, 32'hf);
      wait_done();
      chk("tx_data", fmt(d, md[2], md[3], ct[3]), tx_shift_data);
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
        @(negedge aclk);
        n++;
      end
      chk("delay", 32'd1, n >= 4 * h && n <= 4 * h + 3);
      @(posedge aclk);
      rx_char_data <= d;
      rx_mp_bit <= 1'b1;
      rx_char_valid <= 1'b1;
      @(posedge aclk);
      rx_char_valid <= 1'b0;
      rd(RXDATA_OFS);
      chk("rx_data", fmt(d, md[2], md[3], ct[3]), rd_v);
      rd(STATUS_OFS);
      chk("status", 32'h84, rd_v);
      chk("tx_empty_irq", 32'd1, tx_empty_irq);
      $display("test %0d done", i);
    end
    // Ones on the holding-empty and done bits must leave them alone
    wr(STATUS_OFS, 32'h84);
    rd(STATUS_OFS);
    chk("status", 32'h84, rd_v);
    wr(STATUS_OFS, 32'h80);
    rd(STATUS_OFS);
    chk("status", 32'h80, rd_v);
    $display("test flag clear done");
    err_en <= 1'b1;
    dma(8'h5a);
    wait_done();
    repeat (30) @(posedge aclk);
    err_en <= 1'b0;
    rd(STATUS_OFS);
    chk("status", 32'h90, rd_v);
    wr(CTRL_OFS, 32'h0);
    rd(STATUS_OFS);
    chk("status", 32'h90, rd_v);
    wr(STATUS_OFS, 32'h00);
    rd(STATUS_OFS);
    chk("status", 32'h84, rd_v);
    $display("test error signal done");
    wr(CTRL_OFS, 32'h1);
    wr(MODE_OFS, 32'h0c);
    chk("card_mode", 32'd0, card_mode);
    dma(8'h3c);
    wait_done();
    chk("tx_plain", 32'h3c, tx_shift_data);
    repeat (30) @(posedge aclk);
    rx_char_data <= 8'h96;
    rx_char_valid <= 1'b1;
    @(posedge aclk);
    rx_char_valid <= 1'b0;
    rd(RXDATA_OFS);
    chk("rx_plain", 32'h96, rd_v);
    rd(STATUS_OFS);
    chk("status", 32'h86, rd_v);
    $display("test plain mode done");
    report_and_stop;
  end
endmodule
`default_nettype wire
